// File: rtl/port_special_function_reg.sv
// per-port special function register behind the serial management port
`timescale 1ns/1ps
module port_special_function_reg
    import sfr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR      = 5'h00,
    parameter int         MDIX_SLOT_CYC = sfr_pkg::MDIX_SLOT_CYC,
    parameter int         LPBK_QUAL_CYC = sfr_pkg::LPBK_QUAL_CYC
) (
    input  logic       core_clk,
    input  logic       rst,
    input  logic       mdc,
    input  logic       mdio_in,
    output logic       mdio_out,
    output logic       mdio_oe_n,
    input  logic [1:0] rise_time_strap_pins,
    input  logic [2:0] line_len,
    input  logic       agc_override,
    input  logic       link_good,
    input  logic       lb_seen,
    output logic [1:0] rise_time_sel,
    output logic       auto_mdix_en,
    output logic       pair_swap,
    output logic       analog_loopback,
    output logic       lbd_en,
    output logic       lbd_fast,
    output logic       lbd_detected,
    output logic       line_len_valid
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic       mdc_s1;
    logic       mdc_s2;
    logic       mdc_s3;
    logic       mdi_s1;
    logic       mdi_s2;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic       rise;

    always_ff @(posedge core_clk) begin
        mdc_s1   <= mdc;
        mdc_s2   <= mdc_s1;
        mdc_s3   <= mdc_s2;
        mdi_s1   <= mdio_in;
        mdi_s2   <= mdi_s1;
        strap_s1 <= rise_time_strap_pins;
        strap_s2 <= strap_s1;
    end

    assign rise = mdc_s2 & ~mdc_s3;

    // ----------------------------------------------------------------
    // read word assembly
    // ----------------------------------------------------------------
    function automatic logic [15:0] read_word(
        input logic [2:0] len,
        input logic       agc,
        input logic [1:0] rt,
        input logic       au,
        input logic       px,
        input logic       al,
        input logic       le,
        input logic       lf,
        input logic       ld
    );
        logic [15:0] w;
        w                = 16'h0000; // see RULE11
        w[LEN_HI:LEN_LO] = agc ? LEN_RST : len; // see RULE1 // see RULE2
        w[RISE_HI:RISE_LO] = rt;
        w[AUTO_BIT]      = au;
        w[MDIX_BIT]      = px;
        w[ALB_BIT]       = al;
        w[LBD_EN_BIT]    = le;
        w[LBD_FAST_BIT]  = lf;
        w[LBD_STAT_BIT]  = ld;
        return w;
    endfunction : read_word

    // ----------------------------------------------------------------
    // port engine
    // ----------------------------------------------------------------
    sfr_if eng_if ();

    logic [1:0] rise_r;
    logic [1:0] rise_nxt;
    logic       auto_r;
    logic       auto_nxt;
    logic       mdix_r;
    logic       mdix_nxt;
    logic       alb_r;
    logic       alb_nxt;
    logic       len_r;
    logic       len_nxt;
    logic       fast_r;
    logic       fast_nxt;
    logic       swap_r;
    logic       det_r;
    logic       valid_r;

    assign eng_if.auto_en    = auto_r;
    assign eng_if.manual_sel = mdix_r;
    assign eng_if.lbd_en     = len_r;
    assign eng_if.lbd_fast   = fast_r;
    assign eng_if.link_good  = link_good;
    assign eng_if.lb_seen    = lb_seen;

    sfr_port_engine #(
        .SLOT_CYC (MDIX_SLOT_CYC),
        .QUAL_CYC (LPBK_QUAL_CYC)
    ) u_engine (
        .core_clk (core_clk),
        .rst      (rst),
        .port     (eng_if.engine)
    );

    // ----------------------------------------------------------------
    // management frame machine
    // ----------------------------------------------------------------
    mgmt_state_e st_r;
    mgmt_state_e st_nxt;
    logic [5:0]  cnt_r;
    logic [5:0]  cnt_nxt;
    logic [15:0] sh_r;
    logic [15:0] sh_nxt;
    logic [11:0] hdr;
    logic        rd_r;
    logic        rd_nxt;
    logic        hit_r;
    logic        hit_nxt;
    logic        mo_r;
    logic        mo_nxt;
    logic        oen_r;
    logic        oen_nxt;
    logic        rd_load;
    logic        wr_commit;
    logic [15:0] wdata;

    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        rd_nxt    = rd_r;
        hit_nxt   = hit_r;
        mo_nxt    = mo_r;
        oen_nxt   = oen_r;
        rd_load   = 1'h0;
        wr_commit = 1'h0;
        hdr       = {sh_r[10:0], mdi_s2};
        wdata     = {sh_r[14:0], mdi_s2};
        if (rise) begin
            case (st_r)
                MS_IDLE: begin
                    if (!mdi_s2) begin
                        st_nxt  = (cnt_r == PREAMBLE_ONES) ? MS_START : MS_IDLE;
                        cnt_nxt = '0;
                    end else if (cnt_r != PREAMBLE_ONES) begin
                        cnt_nxt = cnt_r + 6'h01;
                    end
                end
                MS_START: begin
                    st_nxt  = mdi_s2 ? MS_HDR : MS_IDLE;
                    cnt_nxt = '0;
                end
                MS_HDR: begin
                    sh_nxt  = {sh_r[14:0], mdi_s2};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == HDR_LAST) begin
                        cnt_nxt = '0;
                        rd_nxt  = hdr[11:10] == OP_READ;
                        hit_nxt = hdr[4:0] == SFR_REG_ADDR;
                        st_nxt  = MS_IDLE;
                        if (hdr[9:5] == PHY_ADDR &&
                            (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
                            st_nxt = MS_TA;
                        end
                        if (st_nxt == MS_TA && rd_nxt && hit_nxt) begin
                            rd_load = 1'h1;
                            sh_nxt  = read_word(line_len, agc_override, rise_r, auto_r,
                                                swap_r, alb_r, len_r, fast_r, det_r);
                        end
                    end
                end
                MS_TA: begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (rd_r && hit_r) begin
                        oen_nxt = 1'h0;
                        mo_nxt  = (cnt_r == 6'h00) ? 1'h0 : sh_r[15];
                    end
                    if (cnt_r == 6'h01) begin
                        st_nxt  = MS_DATA;
                        cnt_nxt = '0;
                    end
                end
                MS_DATA: begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (rd_r) begin
                        sh_nxt = {sh_r[14:0], 1'h0};
                        mo_nxt = sh_r[14];
                    end else begin
                        sh_nxt = wdata;
                    end
                    if (cnt_r == DATA_LAST) begin
                        st_nxt    = MS_IDLE;
                        cnt_nxt   = '0;
                        oen_nxt   = 1'h1;
                        mo_nxt    = 1'h0;
                        wr_commit = !rd_r && hit_r;
                    end
                end
                default: begin
                    st_nxt  = MS_IDLE;
                    cnt_nxt = '0;
                    oen_nxt = 1'h1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r  <= MS_IDLE;
            cnt_r <= '0;
            sh_r  <= '0;
            rd_r  <= 1'h0;
            hit_r <= 1'h0;
            mo_r  <= 1'h0;
            oen_r <= 1'h1;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r  <= sh_nxt;
            rd_r  <= rd_nxt;
            hit_r <= hit_nxt;
            mo_r  <= mo_nxt;
            oen_r <= oen_nxt;
        end
    end

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    always_comb begin
        rise_nxt = rise_r;
        auto_nxt = auto_r;
        mdix_nxt = mdix_r;
        alb_nxt  = alb_r;
        len_nxt  = len_r;
        fast_nxt = fast_r;
        if (wr_commit) begin
            rise_nxt = wdata[RISE_HI:RISE_LO]; // see RULE3
            auto_nxt = wdata[AUTO_BIT]; // see RULE5
            mdix_nxt = wdata[MDIX_BIT]; // see RULE6
            alb_nxt  = wdata[ALB_BIT]; // see RULE7
            len_nxt  = wdata[LBD_EN_BIT]; // see RULE8
            fast_nxt = wdata[LBD_FAST_BIT]; // see RULE9
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rise_r  <= strap_s2; // see RULE4
            auto_r  <= AUTO_RST;
            mdix_r  <= MDIX_RST;
            alb_r   <= ALB_RST;
            len_r   <= LBD_EN_RST;
            fast_r  <= LBD_FAST_RST;
            swap_r  <= MDIX_RST;
            det_r   <= LBD_STAT_RST;
            valid_r <= 1'h0;
        end else begin
            rise_r  <= rise_nxt;
            auto_r  <= auto_nxt;
            mdix_r  <= mdix_nxt;
            alb_r   <= alb_nxt;
            len_r   <= len_nxt;
            fast_r  <= fast_nxt;
            swap_r  <= eng_if.pair_sel; // see RULE12
            det_r   <= eng_if.lb_det; // see RULE10
            valid_r <= !agc_override; // see RULE2
        end
    end

    assign mdio_out        = mo_r;
    assign mdio_oe_n       = oen_r;
    assign rise_time_sel   = rise_r;
    assign auto_mdix_en    = auto_r;
    assign pair_swap       = swap_r;
    assign analog_loopback = alb_r;
    assign lbd_en          = len_r;
    assign lbd_fast        = fast_r;
    assign lbd_detected    = det_r;
    assign line_len_valid  = valid_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    len_read_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE1
        rd_load && !agc_override |=> sh_r[LEN_HI:LEN_LO] == $past(line_len))
        else $error("line length not captured for read");
    len_mask_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE2
        rd_load && agc_override |=> sh_r[LEN_HI:LEN_LO] == LEN_RST)
        else $error("line length not masked under gain override");
    resv_zero_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE11
        rd_load |=> sh_r[12] == 1'h0 && sh_r[3:0] == 4'h0)
        else $error("reserved bits not read as zero");
    rise_write_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE3
        wr_commit |=> rise_r == $past(wdata[RISE_HI:RISE_LO]) && rise_time_sel == rise_r)
        else $error("rise time field not written");
    rise_strap_a: assert property (@(posedge core_clk) // see RULE4
        $fell(rst) |-> rise_r == $past(strap_s2))
        else $error("rise time not loaded from straps");
    auto_write_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE5
        wr_commit |=> auto_r == $past(wdata[AUTO_BIT]))
        else $error("crossover enable not written");
    alb_write_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE7
        wr_commit |=> analog_loopback == $past(wdata[ALB_BIT]))
        else $error("analog loopback bit not written");
    det_clear_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE10
        !lb_seen |=> ##1 !lbd_detected)
        else $error("loopback flag held without loopback");
    turn_drive_a: assert property (@(posedge core_clk) disable iff (rst)
        rd_load |=> oen_r [*8])
        else $error("bus driven during first turnaround bit");

endmodule : port_special_function_reg

// File: rtl/sfr_if.sv
// carrier between the register front end and the port engine
`timescale 1ns/1ps
interface sfr_if;
    logic auto_en;
    logic manual_sel;
    logic lbd_en;
    logic lbd_fast;
    logic link_good;
    logic lb_seen;
    logic pair_sel;
    logic lb_det;

    modport front (output auto_en, manual_sel, lbd_en, lbd_fast, link_good, lb_seen,
                   input pair_sel, lb_det);
    modport engine (input auto_en, manual_sel, lbd_en, lbd_fast, link_good, lb_seen,
                    output pair_sel, lb_det);
endinterface : sfr_if

// File: rtl/sfr_pkg.sv
// constants and types for the port special function register
//
// How it works
// RULE1 - read-only 3-bit line length in bits 15:13, 111 longest, 000 shortest.
// RULE2 - line length is invalid, read as zero, while gain override bit 30.13 is set.
// RULE3 - bits 11:10 pick transmit rise time 3.3, 3.6, 3.9 or 4.2 ns.
// RULE4 - rise time field loads from strap pins at reset, software may overwrite.
// RULE5 - bit 9 enables automatic crossover, resets to one.
// RULE6 - bit 8 picks pairs: 0 transmit A receive B, 1 the reverse; resets one.
// RULE7 - bit 7 enables analog loopback while still transmitting; resets zero.
// RULE8 - bit 6 enables automatic loopback detection; resets zero.
// RULE9 - bit 5 enables faster loopback detection; resets zero.
// RULE10 - read-only bit 4 shows a detected loopback, zero otherwise and after reset.
// RULE11 - software writes reserved bits 12 and 3:0 as zero and ignores them.
// RULE12 - with crossover automatic, bit 8 reads back the pair choice in use.
package sfr_pkg;

    // ----------------------------------------------------------------
    // register map and fields
    // ----------------------------------------------------------------
    localparam logic [4:0] SFR_REG_ADDR = 5'h1B;
    localparam int         LEN_HI       = 15;
    localparam int         LEN_LO       = 13;
    localparam int         RISE_HI      = 11;
    localparam int         RISE_LO      = 10;
    localparam int         AUTO_BIT     = 9;
    localparam int         MDIX_BIT     = 8;
    localparam int         ALB_BIT      = 7;
    localparam int         LBD_EN_BIT   = 6;
    localparam int         LBD_FAST_BIT = 5;
    localparam int         LBD_STAT_BIT = 4;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [2:0] LEN_RST      = 3'h0;
    localparam logic       AUTO_RST     = 1'h1;
    localparam logic       MDIX_RST     = 1'h1;
    localparam logic       ALB_RST      = 1'h0;
    localparam logic       LBD_EN_RST   = 1'h0;
    localparam logic       LBD_FAST_RST = 1'h0;
    localparam logic       LBD_STAT_RST = 1'h0;

    // ----------------------------------------------------------------
    // rise time codes
    // ----------------------------------------------------------------
    localparam logic [1:0] RISE_3P3NS   = 2'h0;
    localparam logic [1:0] RISE_3P6NS   = 2'h1;
    localparam logic [1:0] RISE_3P9NS   = 2'h2;
    localparam logic [1:0] RISE_4P2NS   = 2'h3;

    // ----------------------------------------------------------------
    // management frame
    // ----------------------------------------------------------------
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [5:0] HDR_LAST      = 6'h0B;
    localparam logic [5:0] DATA_LAST     = 6'h0F;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS        = 100;
    localparam int MDIX_SLOT_US  = 50000;
    localparam int LPBK_QUAL_US  = 2000;
    localparam int LPBK_FAST_US  = 200;
    localparam int MDIX_SLOT_CYC = MDIX_SLOT_US * 1000 / CLK_NS;
    localparam int LPBK_QUAL_CYC = LPBK_QUAL_US * 1000 / CLK_NS;
    localparam int LPBK_FAST_CYC = LPBK_FAST_US * 1000 / CLK_NS;

    typedef enum logic [2:0] {
        MS_IDLE  = 3'h0,
        MS_START = 3'h1,
        MS_HDR   = 3'h2,
        MS_TA    = 3'h3,
        MS_DATA  = 3'h4
    } mgmt_state_e;

endpackage : sfr_pkg

// File: rtl/sfr_port_engine.sv
// crossover search and loopback qualification engine
`timescale 1ns/1ps
module sfr_port_engine
    import sfr_pkg::*;
#(
    parameter int SLOT_CYC = MDIX_SLOT_CYC,
    parameter int QUAL_CYC = LPBK_QUAL_CYC
) (
    input  logic  core_clk,
    input  logic  rst,
    sfr_if.engine port
);

    logic [19:0] slot_r;
    logic [19:0] slot_nxt;
    logic [19:0] qual_r;
    logic [19:0] qual_nxt;
    logic [19:0] lim;
    logic        sel_r;
    logic        sel_nxt;
    logic        det_r;
    logic        det_nxt;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        slot_nxt = slot_r;
        sel_nxt  = sel_r;
        qual_nxt = qual_r;
        det_nxt  = det_r;
        lim      = port.lbd_fast ? 20'(LPBK_FAST_CYC - 1) : 20'(QUAL_CYC - 1); // see RULE9
        if (!port.auto_en) begin
            sel_nxt  = port.manual_sel; // see RULE6
            slot_nxt = '0;
        end else if (port.link_good) begin
            slot_nxt = '0; // see RULE12
        end else if (slot_r == 20'(SLOT_CYC - 1)) begin
            slot_nxt = '0;
            sel_nxt  = ~sel_r; // see RULE5
        end else begin
            slot_nxt = slot_r + 20'h00001;
        end
        if (!port.lbd_en || !port.lb_seen) begin
            qual_nxt = '0; // see RULE8
            det_nxt  = 1'h0;
        end else if (!det_r) begin
            if (qual_r >= lim) begin
                det_nxt = 1'h1; // see RULE10
            end else begin
                qual_nxt = qual_r + 20'h00001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            slot_r <= '0;
            qual_r <= '0;
            sel_r  <= MDIX_RST;
            det_r  <= LBD_STAT_RST;
        end else begin
            slot_r <= slot_nxt;
            qual_r <= qual_nxt;
            sel_r  <= sel_nxt;
            det_r  <= det_nxt;
        end
    end

    assign port.pair_sel = sel_r;
    assign port.lb_det   = det_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    manual_pair_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE6
        !port.auto_en |=> sel_r == $past(port.manual_sel))
        else $error("pair choice does not follow manual bit");
    link_hold_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE12
        port.auto_en && port.link_good |=> $stable(sel_r))
        else $error("pair choice moved while link good");
    det_off_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE8
        !port.lbd_en |=> !det_r)
        else $error("loopback flag set while detection off");
    det_qual_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE9
        $rose(det_r) |-> $past(qual_r) >= $past(lim) && $past(port.lb_seen))
        else $error("loopback flag set before qualification");

endmodule : sfr_port_engine

// File: testbench/mgmt_host.sv
// management controller model driving serial management frames
`timescale 1ns/1ps
module mgmt_host
    import sfr_pkg::*;
(
    input  logic        core_clk,
    input  logic        mdio_line,
    output logic        mdc,
    output logic        mdio_h,
    output logic        rd_done,
    output logic [15:0] rd_data
);
    initial begin
        mdc = 1'b1;
        mdio_h = 1'b1;
        rd_done = 1'b0;
        rd_data = 16'h0000;
    end

    // ----------------------------------------------------------------
    // one management clock period, sample line before the rise
    // ----------------------------------------------------------------
    task put(input logic b, output logic s);
        @(posedge core_clk);
        mdc <= 1'b0;
        mdio_h <= b;
        repeat (5) @(posedge core_clk);
        s = mdio_line;
        mdc <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : put

    // ----------------------------------------------------------------
    // whole frame, released line reads as pull-up
    // ----------------------------------------------------------------
    task xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
        logic [63:0] f;
        logic [15:0] r;
        logic        s;
        f = {32'hFFFFFFFF, 2'b01, op, 5'h00, ra, 2'b10, wd & 16'hEFF0};
        r = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            put((op == OP_READ && i < 18) ? 1'b1 : f[i], s);
            if (i < 16) r[i] = s;
        end
        rd_data <= r & 16'hEFF0;
        rd_done <= (op == OP_READ);
        @(posedge core_clk);
        rd_done <= 1'b0;
    endtask : xfer
endmodule : mgmt_host

// File: testbench/port_special_function_reg_test.sv
// self-checking bench for the port special function register
`timescale 1ns/1ps
module port_special_function_reg_test;
    import sfr_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        mdc, mdio_in, mdio_out, mdio_oe_n, mdio_h, rd_done;
    logic [15:0] rd_data;
    logic [1:0]  strap = 2'h0;
    logic [2:0]  len = 3'h0;
    logic        agc = 1'b0, link_good = 1'b1, lb_seen = 1'b0;
    logic [1:0]  rise_time_sel;
    logic        auto_mdix_en, pair_swap, analog_loopback, lbd_en, lbd_fast;
    logic        lbd_detected, line_len_valid, p;
    logic [15:0] seed = 16'h000C;
    logic [15:0] expq[$];
    int          n_mismatch = 0, n_checks = 0, n;

    always #50 core_clk = ~core_clk;
    assign mdio_in = mdio_oe_n ? mdio_h : (mdio_out & mdio_h);

    port_special_function_reg #(.MDIX_SLOT_CYC(16), .LPBK_QUAL_CYC(3000)) dut (
        .core_clk(core_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .rise_time_strap_pins(strap),
        .line_len(len), .agc_override(agc), .link_good(link_good), .lb_seen(lb_seen),
        .rise_time_sel(rise_time_sel), .auto_mdix_en(auto_mdix_en), .pair_swap(pair_swap),
        .analog_loopback(analog_loopback), .lbd_en(lbd_en), .lbd_fast(lbd_fast),
        .lbd_detected(lbd_detected), .line_len_valid(line_len_valid));

    mgmt_host host (.core_clk(core_clk), .mdio_line(mdio_in), .mdc(mdc), .mdio_h(mdio_h),
        .rd_done(rd_done), .rd_data(rd_data));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function logic [15:0] word(input logic [2:0] l, input logic [1:0] rt,
                               input logic [5:0] b);
        return {l, 1'b0, rt, b, 4'h0};
    endfunction : word

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task wr(input logic [15:0] w);
        host.xfer(OP_WRITE, SFR_REG_ADDR, w);
        repeat (3) @(posedge core_clk);
    endtask : wr

    task rd(input logic [15:0] e);
        expq.push_back(e);
        host.xfer(OP_READ, SFR_REG_ADDR, 16'h0000);
    endtask : rd

    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // read watcher
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rd_done === 1'b1 && expq.size() > 0) begin
            check("read word", rd_data, expq.pop_front());
        end
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = lfsr(seed);
        strap <= seed[1:0];
        len <= seed[4:2];
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("rise strap", rise_time_sel, strap);
        check("auto reset", auto_mdix_en, 1'b1);
        check("pair reset", pair_swap, 1'b1);
        check("ctl reset", {analog_loopback, lbd_en, lbd_fast, lbd_detected}, 4'h0);
        rd(word(len, strap, 6'h30));
        expq.push_back(16'hEFF0);
        host.xfer(OP_READ, 5'h1A, 16'h0000);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            seed = lfsr(seed);
            len <= seed[6:4];
            wr(word(3'h7, c[1:0], {1'b0, seed[3:0], 1'b0}) | 16'h0010);
            check("rise sel", rise_time_sel, c[1:0]);
            check("pair sel", pair_swap, seed[3]);
            check("analog lb", analog_loopback, seed[2]);
            check("lbd en", lbd_en, seed[1]);
            check("lbd fast", lbd_fast, seed[0]);
            rd(word(len, c[1:0], {1'b0, seed[3:0], 1'b0}));
        end
        $display("test fields done");
        agc <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("len valid", line_len_valid, 1'b0);
        rd(word(3'h0, 2'h3, {1'b0, seed[3:0], 1'b0}));
        agc <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("len valid", line_len_valid, 1'b1);
        $display("test gain done");
        wr(word(3'h0, 2'h3, 6'h06));
        lb_seen <= 1'b1;
        repeat (LPBK_FAST_CYC - 10) @(posedge core_clk);
        check("fast early", lbd_detected, 1'b0);
        repeat (30) @(posedge core_clk);
        check("fast det", lbd_detected, 1'b1);
        rd(word(len, 2'h3, 6'h07));
        lb_seen <= 1'b0;
        repeat (4) @(posedge core_clk);
        check("lb gone", lbd_detected, 1'b0);
        wr(word(3'h0, 2'h3, 6'h04));
        lb_seen <= 1'b1;
        repeat (2100) @(posedge core_clk);
        check("slow early", lbd_detected, 1'b0);
        repeat (930) @(posedge core_clk);
        check("slow det", lbd_detected, 1'b1);
        wr(word(3'h0, 2'h3, 6'h00));
        check("lbd off", lbd_detected, 1'b0);
        lb_seen <= 1'b0;
        $display("test loopback done");
        wr(word(3'h0, 2'h3, 6'h20));
        link_good <= 1'b0;
        repeat (8) @(posedge core_clk);
        n = 0;
        p = pair_swap;
        repeat (64) begin
            @(posedge core_clk);
            if (pair_swap !== p) n++;
            p = pair_swap;
        end
        check("swap count", n[15:0], 16'h0004);
        link_good <= 1'b1;
        repeat (3) @(posedge core_clk);
        p = pair_swap;
        repeat (64) @(posedge core_clk);
        check("swap hold", pair_swap, p);
        rd(word(len, 2'h3, {1'b1, p, 4'h0}));
        repeat (4) @(posedge core_clk);
        $display("test crossover done");
        wrap_up();
    end
endmodule : port_special_function_reg_test
